// File: src/dcm_pkg.sv
// Shared constants for the two-channel encoder safety monitor.
// Assumes a 50 MHz system clock at both ends of the link.
package dcm_pkg;
  // Word and sample widths
  localparam int POS_W  = 12;
  localparam int ERR_W  = 2;
  localparam int WORD_W = POS_W + ERR_W;
  localparam int AMP_W  = 12;
  localparam int SQ_W   = 2 * AMP_W + 1;
  localparam int TMR_W  = 12;
  localparam int BIT_W  = 5;

  // Error bit positions in the serial word
  localparam int ERR_SUPPLY_BIT = 0;
  localparam int ERR_TEMP_BIT   = 1;

  // Timing in ns or us as printed, and derived cycle counts
  localparam int CLK_NS      = 20;
  localparam int SSI_HALF_NS = 160;
  localparam int MONO_US     = 20;
  localparam int GAP_US      = 30;
  localparam logic [TMR_W-1:0] SSI_HALF_CYC =
    TMR_W'((SSI_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] MONO_CYC = TMR_W'(MONO_US * 1000 / CLK_NS);
  localparam logic [TMR_W-1:0] GAP_CYC  = TMR_W'(GAP_US * 1000 / CLK_NS);

  // Vector length limits on k squared, nominal k of 1024
  localparam logic [SQ_W-1:0] NOM_SQ = 25'h010_0000;
  localparam logic [SQ_W-1:0] VEC_LO = 25'h004_0000;
  localparam logic [SQ_W-1:0] VEC_HI = 25'h024_0000;
  localparam logic signed [AMP_W-1:0] AMP_MAX = 12'h07FF;

  // Cross-channel deviation in counts at which the compare check trips
  localparam logic [POS_W-1:0] DEV_MAX = 12'h0004;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 14'h0000;
  localparam logic [POS_W-1:0]  POS_RST  = 12'h0000;
endpackage : dcm_pkg

// File: src/dcm_if.sv
// Link between the encoder end and the evaluation end.
// Assumes both ends run from their own 50 MHz clock.
`timescale 1ns/10ps
interface dcm_if;
  import dcm_pkg::*;
  logic                    quad_a;   // Square wave from sine
  logic                    quad_b;   // Square wave from cosine
  logic signed [AMP_W-1:0] sin_amp;  // Differential sine sample
  logic signed [AMP_W-1:0] cos_amp;  // Differential cosine sample
  logic                    ssi_clk;  // Serial clock, made by evaluator
  logic                    ssi_data; // Serial data, made by encoder

  // Encoder end
  modport enc (output quad_a, quad_b, sin_amp, cos_amp, ssi_data,
               input ssi_clk);
  // Evaluation end
  modport eval (input quad_a, quad_b, sin_amp, cos_amp, ssi_data,
                output ssi_clk);
endinterface : dcm_if

// File: src/dcm_quad.sv
// Four-fold quadrature counter with loadable start position.
// Assumes a and b are already synchronised to clock.
`timescale 1ns/10ps
module dcm_quad (
  input  wire logic                     clock,    // System clock
  input  wire logic                     rst,      // Async reset
  input  wire logic                     a,        // Sine square wave
  input  wire logic                     b,        // Cosine square wave
  input  wire logic                     load,     // Load start position
  input  wire logic [dcm_pkg::POS_W-1:0] load_val, // Start position
  output logic      [dcm_pkg::POS_W-1:0] count,    // Counted position
  output logic                          dir       // 1 = counting up
);
  import dcm_pkg::*;
  logic [1:0]       ph_r, ph_nxt;
  logic [POS_W-1:0] cnt_r, cnt_nxt;
  logic             dir_r, dir_nxt;
  logic [1:0]       ph_now, step;

  // Phase decode and count step
  always_comb begin
    ph_now  = {a, a ^ b};
    step    = ph_now - ph_r;
    ph_nxt  = ph_now;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (step == 2'd1) begin
      cnt_nxt = cnt_r + POS_W'(1);
      dir_nxt = 1'b1;
    end else if (step == 2'd3) begin
      cnt_nxt = cnt_r - POS_W'(1);
      dir_nxt = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_r  <= 2'h0;
      cnt_r <= POS_RST;
      dir_r <= 1'b1;
    end else begin
      ph_r  <= ph_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign count = cnt_r;
  assign dir   = dir_r;
endmodule : dcm_quad

// File: src/dcm_encoder.sv
// Encoder end: quadrature, analog samples and serial position word.
// Assumes the serial clock arrives unsynchronised from the evaluator.
`timescale 1ns/10ps
module dcm_encoder (
  input  wire logic                     clock,     // System clock
  input  wire logic                     rst,       // Async reset
  dcm_if.enc                            link,      // Link to evaluator
  input  wire logic [dcm_pkg::POS_W-1:0] pos_in,    // Optical position
  input  wire logic [dcm_pkg::AMP_W-2:0] amp_in,    // Signal amplitude
  input  wire logic                     supply_ok, // Supply in range
  input  wire logic                     temp_ok,   // Temperature in range
  input  wire logic                     mask_lost, // Source masking lost
  input  wire logic                     fault_in   // Other internal fault
);
  import dcm_pkg::*;
  typedef enum logic [1:0] {ES_IDLE, ES_SHIFT, ES_MONO} dcm_es_t;

  dcm_es_t                 st_r, st_nxt;
  logic [2:0]              sc_r;
  logic [WORD_W-1:0]       sh_r, sh_nxt;
  logic [BIT_W-1:0]        nb_r, nb_nxt;
  logic [TMR_W-1:0]        tm_r, tm_nxt;
  logic                    dat_r, dat_nxt;
  logic                    qa_r, qb_r;
  logic signed [AMP_W-1:0] sin_r, cos_r;
  logic                    fall, rise, any_err;
  logic [ERR_W-1:0]        err_bits;
  logic signed [AMP_W-1:0] amp_s;

  // Serial clock synchroniser and edge finder
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sc_r <= 3'b111;
    else     sc_r <= {sc_r[1:0], link.ssi_clk};
  end
  assign fall = sc_r[2] & ~sc_r[1];
  assign rise = ~sc_r[2] & sc_r[1];

  // Serial word sequencer
  always_comb begin
    err_bits                 = '0;
    err_bits[ERR_SUPPLY_BIT] = ~supply_ok;
    err_bits[ERR_TEMP_BIT]   = ~temp_ok;
    any_err = fault_in | (|err_bits);
    st_nxt  = st_r;
    sh_nxt  = sh_r;
    nb_nxt  = nb_r;
    dat_nxt = dat_r;
    tm_nxt  = (fall | rise) ? '0 : tm_r + TMR_W'(1);
    case (st_r)
      ES_IDLE: begin
        dat_nxt = 1'b1;
        tm_nxt  = '0;
        if (fall) begin
          sh_nxt = any_err ? '1 : {pos_in, err_bits};
          nb_nxt = BIT_W'(WORD_W);
          st_nxt = ES_SHIFT;
        end
      end
      ES_SHIFT: begin
        if (rise) begin
          if (nb_r != '0) begin
            dat_nxt = sh_r[WORD_W-1];
            sh_nxt  = {sh_r[WORD_W-2:0], 1'b0};
            nb_nxt  = nb_r - BIT_W'(1);
          end else begin
            dat_nxt = 1'b0;
            st_nxt  = ES_MONO;
          end
        end else if (tm_r >= MONO_CYC) begin
          st_nxt = ES_IDLE;
        end
      end
      ES_MONO: begin
        dat_nxt = 1'b0;
        if (tm_r >= MONO_CYC) st_nxt = ES_IDLE;
      end
      default: st_nxt = ES_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r  <= ES_IDLE;
      sh_r  <= WORD_RST;
      nb_r  <= '0;
      tm_r  <= '0;
      dat_r <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      sh_r  <= sh_nxt;
      nb_r  <= nb_nxt;
      tm_r  <= tm_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Channel 1 outputs from the optical position
  assign amp_s = {1'b0, amp_in};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qa_r  <= 1'b0;
      qb_r  <= 1'b0;
      sin_r <= '0;
      cos_r <= '0;
    end else begin
      qa_r <= pos_in[1];
      qb_r <= pos_in[1] ^ pos_in[0];
      // lost masking drives both to max
      sin_r <= mask_lost ? AMP_MAX : (pos_in[1] ? amp_s : -amp_s);
      cos_r <= mask_lost ? AMP_MAX
             : ((pos_in[1] ^ pos_in[0]) ? amp_s : -amp_s);
    end
  end

  assign link.quad_a   = qa_r;
  assign link.quad_b   = qb_r;
  assign link.sin_amp  = sin_r;
  assign link.cos_amp  = cos_r;
  assign link.ssi_data = dat_r;
endmodule : dcm_encoder

// File: src/dcm_eval.sv
// Evaluation end: serial master, counter, and the three diagnostics.
// Assumes all link inputs are asynchronous to this clock.
`timescale 1ns/10ps
module dcm_eval (
  input  wire logic                     clock,      // System clock
  input  wire logic                     rst,        // Async reset
  dcm_if.eval                           link,       // Link to encoder
  input  wire logic [dcm_pkg::POS_W-1:0] start_pos,  // Counter start value
  input  wire logic                     load_pos,   // Load start value
  input  wire logic                     clr_err,    // Clear sticky errors
  output logic      [dcm_pkg::POS_W-1:0] abs_pos,    // Last serial position
  output logic      [dcm_pkg::POS_W-1:0] cnt_pos,    // Counted position
  output logic                          dir,        // Counting direction
  output logic                          safe_valid, // Data usable
  output logic                          err_vec,    // Sticky vector error
  output logic                          err_ssi,    // Sticky serial error
  output logic                          err_cmp,    // Sticky compare error
  output logic                          safe_state, // Safe state request
  output logic                          round_done  // Check round pulse
);
  import dcm_pkg::*;
  typedef enum logic [1:0] {MS_GAP, MS_LOW, MS_HIGH, MS_DONE} dcm_ms_t;

  logic [1:0]              qa_s, qb_s, dat_s;
  logic signed [AMP_W-1:0] sin_s1, sin_s2, cos_s1, cos_s2;
  logic [2*AMP_W-1:0]      sin_sq, cos_sq;
  logic [SQ_W-1:0]         mag_sq;
  logic                    vec_bad_r, vec_bad_nxt;

  dcm_ms_t          st_r, st_nxt;
  logic [TMR_W-1:0] tm_r, tm_nxt;
  logic [BIT_W-1:0] nb_r, nb_nxt;
  logic [WORD_W-1:0] word_r, word_nxt;
  logic [POS_W-1:0] qlat_r, qlat_nxt;
  logic [POS_W-1:0] abs_r, abs_nxt;
  logic             sck_r, sck_nxt;
  logic             done_r, done_nxt;
  logic [POS_W-1:0] diff, dev;
  logic             ssi_bad, cmp_bad;

  logic             ev_r, es_r, ec_r, ok_r;
  logic             ev_nxt, es_nxt, ec_nxt, ok_nxt;
  logic [POS_W-1:0] qcount;
  logic             qdir;

  // Two-flop synchronisers for all link inputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qa_s   <= 2'b00;
      qb_s   <= 2'b00;
      dat_s  <= 2'b11;
      sin_s1 <= '0;
      sin_s2 <= '0;
      cos_s1 <= '0;
      cos_s2 <= '0;
    end else begin
      qa_s   <= {qa_s[0], link.quad_a};
      qb_s   <= {qb_s[0], link.quad_b};
      dat_s  <= {dat_s[0], link.ssi_data};
      sin_s1 <= link.sin_amp;
      sin_s2 <= sin_s1;
      cos_s1 <= link.cos_amp;
      cos_s2 <= cos_s1;
    end
  end

  // Channel 1 counter, never seeded from the serial channel
  dcm_quad u_quad (
    .clock    (clock),
    .rst      (rst),
    .a        (qa_s[1]),
    .b        (qb_s[1]),
    .load     (load_pos),
    .load_val (start_pos),
    .count    (qcount),
    .dir      (qdir)
  );

  // Vector length check on squared magnitude
  always_comb begin
    sin_sq = (2*AMP_W)'(sin_s2 * sin_s2);
    cos_sq = (2*AMP_W)'(cos_s2 * cos_s2);
    mag_sq = {1'b0, sin_sq} + {1'b0, cos_sq};
    // wide band, low side is undervoltage
    vec_bad_nxt = (mag_sq < VEC_LO) || (mag_sq > VEC_HI);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) vec_bad_r <= 1'b0;
    else     vec_bad_r <= vec_bad_nxt;
  end

  // Serial master and frame checks
  always_comb begin
    st_nxt   = st_r;
    tm_nxt   = tm_r + TMR_W'(1);
    nb_nxt   = nb_r;
    word_nxt = word_r;
    qlat_nxt = qlat_r;
    abs_nxt  = abs_r;
    sck_nxt  = sck_r;
    done_nxt = 1'b0;
    // difference of serial and counted position
    diff = word_r[WORD_W-1:ERR_W] - qlat_r;
    dev  = diff[POS_W-1] ? POS_W'(-diff) : diff;
    // any set error bit is an error
    ssi_bad = |word_r[ERR_W-1:0];
    cmp_bad = dev >= DEV_MAX;
    case (st_r)
      // fixed gap bounds the check round
      MS_GAP: begin
        sck_nxt = 1'b1;
        if (tm_r >= GAP_CYC) begin
          st_nxt   = MS_LOW;
          sck_nxt  = 1'b0;
          tm_nxt   = '0;
          nb_nxt   = '0;
          qlat_nxt = qcount;
        end
      end
      MS_LOW: begin
        if (tm_r >= SSI_HALF_CYC - TMR_W'(1)) begin
          if (nb_r != '0) word_nxt = {word_r[WORD_W-2:0], dat_s[1]};
          st_nxt  = MS_HIGH;
          sck_nxt = 1'b1;
          tm_nxt  = '0;
          nb_nxt  = nb_r + BIT_W'(1);
        end
      end
      MS_HIGH: begin
        if (tm_r >= SSI_HALF_CYC - TMR_W'(1)) begin
          tm_nxt = '0;
          if (nb_r == BIT_W'(WORD_W + 1)) begin
            st_nxt = MS_DONE;
          end else begin
            st_nxt  = MS_LOW;
            sck_nxt = 1'b0;
          end
        end
      end
      MS_DONE: begin
        abs_nxt  = word_r[WORD_W-1:ERR_W];
        done_nxt = 1'b1;
        tm_nxt   = '0;
        st_nxt   = MS_GAP;
      end
      default: st_nxt = MS_GAP;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r   <= MS_GAP;
      tm_r   <= '0;
      nb_r   <= '0;
      word_r <= WORD_RST;
      qlat_r <= POS_RST;
      abs_r  <= POS_RST;
      sck_r  <= 1'b1;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tm_r   <= tm_nxt;
      nb_r   <= nb_nxt;
      word_r <= word_nxt;
      qlat_r <= qlat_nxt;
      abs_r  <= abs_nxt;
      sck_r  <= sck_nxt;
      done_r <= done_nxt;
    end
  end

  // Sticky error flags, a new fault beats the clear
  always_comb begin
    // all three checks feed the reaction
    ev_nxt = vec_bad_r | (ev_r & ~clr_err);
    es_nxt = (st_r == MS_DONE && ssi_bad) | (es_r & ~clr_err);
    ec_nxt = (st_r == MS_DONE && cmp_bad) | (ec_r & ~clr_err);
    ok_nxt = ok_r;
    if (st_r == MS_DONE) ok_nxt = ~ssi_bad & ~cmp_bad;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev_r <= 1'b0;
      es_r <= 1'b0;
      ec_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      ev_r <= ev_nxt;
      es_r <= es_nxt;
      ec_r <= ec_nxt;
      ok_r <= ok_nxt;
    end
  end

  assign link.ssi_clk = sck_r;
  assign abs_pos      = abs_r;
  assign cnt_pos      = qcount;
  assign dir          = qdir;
  assign err_vec      = ev_r;
  assign err_ssi      = es_r;
  assign err_cmp      = ec_r;
  assign safe_state   = ev_r | es_r | ec_r;
  // valid only when no error stands
  assign safe_valid   = ok_r & ~(ev_r | es_r | ec_r);
  assign round_done   = done_r;
endmodule : dcm_eval

// File: test/dcm_chk.sv
// Link checker: serial framing, data timing, analog and quadrature pins.
// Assumes it sits beside the link, on the shared 50 MHz clock.
`timescale 1ns/10ps
module dcm_chk (
  input wire logic                              clock,    // System clock
  input wire logic                              rst,      // Async reset
  input wire logic                              quad_a,   // Sine square
  input wire logic                              quad_b,   // Cosine square
  input wire logic signed [dcm_pkg::AMP_W-1:0] sin_amp,  // Sine sample
  input wire logic signed [dcm_pkg::AMP_W-1:0] cos_amp,  // Cosine sample
  input wire logic                              ssi_clk,  // Serial clock
  input wire logic                              ssi_data  // Serial data
);
  import dcm_pkg::*;
  logic [TMR_W-1:0] hi_cnt_r, hi_cnt_nxt;
  logic [4:0]       rise_cnt_r, rise_cnt_nxt;
  logic             prev_r;
  logic [AMP_W-1:0] sin_mag, cos_mag;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Magnitudes of the analog samples
  assign sin_mag = sin_amp[AMP_W-1] ? AMP_W'(-sin_amp) : AMP_W'(sin_amp);
  assign cos_mag = cos_amp[AMP_W-1] ? AMP_W'(-cos_amp) : AMP_W'(cos_amp);

  // High-phase length and rises per frame
  always_comb begin
    hi_cnt_nxt   = hi_cnt_r;
    rise_cnt_nxt = rise_cnt_r;
    if (!ssi_clk)
      hi_cnt_nxt = '0;
    else if (hi_cnt_r != '1)
      hi_cnt_nxt = hi_cnt_r + TMR_W'(1);
    if (ssi_clk && !prev_r)
      rise_cnt_nxt = rise_cnt_r + 5'd1;
    else if (!ssi_clk && prev_r && hi_cnt_r > TMR_W'(8))
      rise_cnt_nxt = '0;
  end

  // Registers of the helper counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt_r   <= '0;
      rise_cnt_r <= '0;
      prev_r     <= 1'b1;
    end else begin
      hi_cnt_r   <= hi_cnt_nxt;
      rise_cnt_r <= rise_cnt_nxt;
      prev_r     <= ssi_clk;
    end
  end

  chk_low_half: assert property (
    $fell(ssi_clk) |-> !ssi_clk [*8] ##1 ssi_clk)
    else $error("serial clock low phase length wrong");
  chk_high_half: assert property (
    $rose(ssi_clk) |-> ssi_clk [*8])
    else $error("serial clock high phase too short");
  chk_frame_bits: assert property (
    hi_cnt_r == TMR_W'(9) && rise_cnt_r != '0 |-> rise_cnt_r == 5'd15)
    else $error("frame rise count wrong");
  chk_gap_mono: assert property (
    $fell(ssi_clk) && hi_cnt_r > TMR_W'(8) |-> hi_cnt_r > MONO_CYC)
    else $error("frame started inside monoflop time");
  chk_idle_high: assert property (
    $fell(ssi_clk) && hi_cnt_r > TMR_W'(8) |-> $past(ssi_data))
    else $error("data not idle high at request");
  chk_data_steady: assert property (
    !ssi_clk && !$past(ssi_clk) && rise_cnt_r != '0 |-> $stable(ssi_data))
    else $error("data changed in low phase");
  chk_mag_equal: assert property (
    sin_mag == cos_mag)
    else $error("sine and cosine magnitudes differ");
  chk_quad_step: assert property (
    !($changed(quad_a) && $changed(quad_b)))
    else $error("both square waves changed at once");

  cov_frame: cover property (hi_cnt_r == TMR_W'(9) && rise_cnt_r == 5'd15);
  cov_zero: cover property (rise_cnt_r != '0 && !ssi_data);
  cov_quad: cover property ($changed(quad_b));
endmodule : dcm_chk

// File: test/dcm_tb.sv
// Bench: encoder end joined to evaluation end, scenarios per task.
// Assumes one 50 MHz clock for both ends; eval makes the link clock.
`timescale 1ns/10ps
module dcm_tb;
  import dcm_pkg::*;
  // Ceiling: about 17 frames of 1742 cycles plus margin
  localparam int LIMIT = 40000;
  localparam logic [AMP_W-2:0] AMPS [5] =
    '{11'h16A, 11'h16B, 11'h43E, 11'h43F, 11'h2D4};
  localparam logic [4:0] VBAD = 5'h19;
  localparam logic [POS_W-1:0] DEVS [4] =
    '{12'h005, 12'h003, 12'hFFD, 12'h004};
  logic             clock, rst, load_pos, clr_err;
  logic [POS_W-1:0] pos_in, start_pos, abs_pos, cnt_pos;
  logic [AMP_W-2:0] amp_in;
  logic             supply_ok, temp_ok, mask_lost, fault_in;
  logic             dir, safe_valid, err_vec, err_ssi, err_cmp;
  logic             safe_state, round_done;
  int               num_errors, n_compared, cyc;

  dcm_if link ();
  dcm_encoder u_dcm_encoder (.clock(clock), .rst(rst), .link(link),
    .pos_in(pos_in), .amp_in(amp_in), .supply_ok(supply_ok),
    .temp_ok(temp_ok), .mask_lost(mask_lost), .fault_in(fault_in));
  dcm_eval u_dcm_eval (.clock(clock), .rst(rst), .link(link),
    .start_pos(start_pos), .load_pos(load_pos), .clr_err(clr_err),
    .abs_pos(abs_pos), .cnt_pos(cnt_pos), .dir(dir),
    .safe_valid(safe_valid), .err_vec(err_vec), .err_ssi(err_ssi),
    .err_cmp(err_cmp), .safe_state(safe_state), .round_done(round_done));
  dcm_chk u_dcm_chk (.clock(clock), .rst(rst), .quad_a(link.quad_a),
    .quad_b(link.quad_b), .sin_amp(link.sin_amp), .cos_amp(link.cos_amp),
    .ssi_clk(link.ssi_clk), .ssi_data(link.ssi_data));

  // Clock and cycle ceiling
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [POS_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Walk position one quadrant at a time
  task automatic walk(input int n, input logic up);
    repeat (n) begin
      pos_in = up ? pos_in + 1'b1 : pos_in - 1'b1;
      step(6);
    end
  endtask : walk

  task automatic wait_round();
    int k;
    k = 0;
    do begin
      step(1);
      k++;
    end while (round_done !== 1'b1 && k < 2500);
    check(k < 2500, 1'b1);
  endtask : wait_round

  task automatic pulse_clr();
    clr_err = 1'b1;
    step(1);
    clr_err = 1'b0;
    step(1);
  endtask : pulse_clr

  // Zero amplitude while the encoder starts must trip the low limit
  task automatic t_reset();
    check(link.ssi_clk, 1'b1);
    check(link.ssi_data, 1'b1);
    check(safe_valid, 1'b0);
    check(safe_state, 1'b0);
    step(10);
    check(err_vec, 1'b1);
    start_pos = pos_in;
    load_pos = 1'b1;
    step(1);
    load_pos = 1'b0;
    pulse_clr();
    check(safe_state, 1'b0);
  endtask : t_reset

  task automatic t_count();
    logic [POS_W-1:0] base;
    base = pos_in;
    walk(5, 1'b1);
    check(cnt_pos, base + 12'h005);
    check(dir, 1'b1);
    walk(5, 1'b0);
    check(cnt_pos, base);
    check(dir, 1'b0);
    repeat (3) begin
      walk(1, 1'b1);
      walk(1, 1'b0);
    end
    check(cnt_pos, base);
  endtask : t_count

  task automatic t_frame();
    logic [POS_W-1:0] p;
    int k;
    wait_round();
    k = 0;
    while (link.ssi_clk !== 1'b0 && k < 2500) begin
      step(1);
      k++;
    end
    p = pos_in;
    step(40);
    walk(1, 1'b1);
    wait_round();
    check(abs_pos, p);
    check(err_cmp, 1'b0);
    check(safe_valid, 1'b1);
    step(1);
    check(round_done, 1'b0);
    wait_round();
  endtask : t_frame

  task automatic t_ssi_err();
    for (int i = 0; i < 3; i++) begin
      supply_ok = (i != 0);
      temp_ok = (i != 1);
      fault_in = (i == 2);
      wait_round();
      check(err_ssi, 1'b1);
      check(safe_state, 1'b1);
      check(safe_valid, 1'b0);
      supply_ok = 1'b1;
      temp_ok = 1'b1;
      fault_in = 1'b0;
      wait_round();
      check(err_ssi, 1'b1);
      pulse_clr();
      check(err_ssi, 1'b0);
      wait_round();
      check(safe_valid, 1'b1);
    end
  endtask : t_ssi_err

  task automatic t_vector();
    for (int i = 0; i < 5; i++) begin
      amp_in = AMPS[i];
      mask_lost = (i == 4);
      step(12);
      check(err_vec, VBAD[i]);
      amp_in = 11'h2D4;
      mask_lost = 1'b0;
      step(12);
      pulse_clr();
      check(err_vec, 1'b0);
    end
  endtask : t_vector

  task automatic t_deviation();
    walk(4, 1'b1);
    wait_round();
    // Deviation equal to the bound is not below it
    for (int i = 0; i < 4; i++) begin
      start_pos = pos_in + DEVS[i];
      load_pos = 1'b1;
      step(1);
      load_pos = 1'b0;
      pulse_clr();
      wait_round();
      check(err_cmp, i == 0 || i == 3);
      check(safe_valid, i == 1 || i == 2);
    end
  endtask : t_deviation

  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    pos_in = 12'hFFC;
    start_pos = 12'h000;
    amp_in = 11'h2D4;
    supply_ok = 1'b1;
    temp_ok = 1'b1;
    mask_lost = 1'b0;
    fault_in = 1'b0;
    load_pos = 1'b0;
    clr_err = 1'b0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    step(1);
    t_reset();
    t_count();
    t_frame();
    t_ssi_err();
    t_vector();
    t_deviation();
    final_report();
  end
endmodule : dcm_tb
